/* logic/api_response_frame_builder.sv */
// Response framer: turns command, modem and transmit events into API frames.
// Assumes a byte sink with valid/ready; request sources hold valid until taken.
//
// Overview of operation
// - Local command request types 0x08/0x09 produce a 0x88 response frame.
// - Several command responses per request are allowed; each is framed.
// - Command response offset 4 echoes the request frame identifier.
// - Command response offsets 5-6 carry the two command name characters.
// - Offset 7 outcome: 0 ok, 1 error, 2 unknown command, 3 bad parameter.
// - Query data follows from offset 8; omitted entirely for register writes.
// - Modem status frame 0x8A: 0x00 hardware reset, 0x01 watchdog reset.
// - Modem status 0x0B on network wake, 0x0C on network sleep.
// - After reset one modem status frame reporting hardware reset is sent.
// - Completed transmit requests 0x10/0x11 produce a 0x8B result frame.
// - Result echoes frame identifier; identifier zero suppresses the frame.
// - Offsets 5-6 hold delivery address; 0xFFFD on any failure.
// - Offset 7 reports the application retry count.
// - Delivery codes 0x00, 0x01, 0x02, 0x21, 0x25 at offset 8.
// - Delivery codes 0x31 resource shortage, 0x32 other internal error.
// - Offset 9: 0x00 no discovery, 0x02 route discovery performed.
`default_nettype none
`include "api_response_frame_builder_params.svh"

module api_response_frame_builder #(
  parameter int DATA_BYTES = `CMD_DATA_MAX
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Command response request
  input wire logic cmd_valid,
  input wire api_response_pkg::cmd_resp_t cmd_req,
  output logic cmd_ready,
  // Modem status event
  input wire logic stat_valid,
  input wire api_response_pkg::modem_event_t stat_event,
  output logic stat_ready,
  // Transmit result request
  input wire logic tx_valid,
  input wire api_response_pkg::tx_result_t tx_req,
  output logic tx_ready,
  // Serial byte stream
  output logic [7:0] out_byte,
  output logic out_valid,
  input wire logic out_ready,
  output logic busy
);

  localparam int FLEN = 5 + DATA_BYTES;

  typedef enum logic [2:0] {S_IDLE, S_DELIM, S_LEN_HI, S_LEN_LO, S_DATA, S_CSUM} state_t;

  state_t state;
  logic pwr_pend;
  logic [7:0] fbuf [FLEN];
  logic [7:0] flen;
  logic [7:0] idx;
  logic [7:0] sum;

  // ==========================================================================
  // Code mapping

  function automatic logic [7:0] outcome_code(input api_response_pkg::cmd_outcome_t o);
    unique case (o)
      api_response_pkg::CMD_OK: outcome_code = `CMD_ST_OK;
      api_response_pkg::CMD_ERROR: outcome_code = `CMD_ST_ERROR;
      api_response_pkg::CMD_BAD_CMD: outcome_code = `CMD_ST_BAD_CMD;
      api_response_pkg::CMD_BAD_PARAM: outcome_code = `CMD_ST_BAD_PARAM;
    endcase
  endfunction

  function automatic logic [7:0] modem_code(input api_response_pkg::modem_event_t e);
    unique case (e)
      api_response_pkg::EV_HW_RESET: modem_code = `MODEM_HW_RESET;
      api_response_pkg::EV_WATCHDOG: modem_code = `MODEM_WATCHDOG;
      api_response_pkg::EV_WAKE: modem_code = `MODEM_WAKE;
      api_response_pkg::EV_SLEEP: modem_code = `MODEM_SLEEP;
    endcase
  endfunction

  // Enum has one unused code, so a default is kept
  function automatic logic [7:0] delivery_code(input api_response_pkg::delivery_t d);
    unique case (d)
      api_response_pkg::DLV_OK: delivery_code = `DLV_CODE_OK;
      api_response_pkg::DLV_MAC_ACK: delivery_code = `DLV_CODE_MAC_ACK;
      api_response_pkg::DLV_CCA: delivery_code = `DLV_CODE_CCA;
      api_response_pkg::DLV_NET_ACK: delivery_code = `DLV_CODE_NET_ACK;
      api_response_pkg::DLV_NO_ROUTE: delivery_code = `DLV_CODE_NO_ROUTE;
      api_response_pkg::DLV_RESOURCE: delivery_code = `DLV_CODE_RESOURCE;
      default: delivery_code = `DLV_CODE_INTERNAL;
    endcase
  endfunction

  // ==========================================================================
  // Request acceptance

  logic idle;
  logic take_pwr;
  logic take_cmd;
  logic take_stat;
  logic take_tx;
  logic any_take;
  logic cmd_ok;
  logic tx_ok;
  logic go;

  assign idle = (state == S_IDLE);
  assign take_pwr = ce && idle && pwr_pend;
  assign take_stat = ce && stat_valid && stat_ready;
  assign take_tx = ce && tx_valid && tx_ready;
  assign take_cmd = ce && cmd_valid && cmd_ready;
  assign any_take = take_pwr || take_stat || take_tx || take_cmd;
  assign cmd_ok = (cmd_req.req_type == `REQ_AT_LOCAL) || (cmd_req.req_type == `REQ_AT_QUEUED);
  assign tx_ok = ((tx_req.req_type == `REQ_TX_PLAIN) || (tx_req.req_type == `REQ_TX_EXPLICIT))
                 && (tx_req.frame_id != 8'h00);
  assign go = take_pwr || take_stat || (take_tx && tx_ok) || (take_cmd && cmd_ok);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwr_pend <= 1'b1;
    end else if (take_pwr) begin
      pwr_pend <= 1'b0;
    end
  end

  // Fixed priority: modem status, then transmit result, then command response.
  // Grant is registered one cycle ahead, so readies come straight from flops.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat_ready <= 1'b0;
      tx_ready <= 1'b0;
      cmd_ready <= 1'b0;
    end else if (ce) begin
      stat_ready <= idle && !any_take && !pwr_pend && stat_valid;
      tx_ready <= idle && !any_take && !pwr_pend && !stat_valid && tx_valid;
      cmd_ready <= idle && !any_take && !pwr_pend && !stat_valid && !tx_valid && cmd_valid;
    end
  end

  // ==========================================================================
  // Frame data buffer

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flen <= 8'h00;
      for (int i = 0; i < FLEN; i++) begin
        fbuf[i] <= 8'h00;
      end
    end else if (take_pwr || take_stat) begin
      fbuf[0] <= `RSP_MODEM;
      fbuf[1] <= take_pwr ? `MODEM_HW_RESET : modem_code(stat_event);
      flen <= `MODEM_LEN;
    end else if (take_tx) begin
      fbuf[0] <= `RSP_TX;
      fbuf[1] <= tx_req.frame_id;
      fbuf[2] <= (tx_req.delivery == api_response_pkg::DLV_OK) ? tx_req.net_addr[15:8]
                 : 8'(`ADDR_UNKNOWN >> 8);
      fbuf[3] <= (tx_req.delivery == api_response_pkg::DLV_OK) ? tx_req.net_addr[7:0]
                 : 8'(`ADDR_UNKNOWN & 16'h00ff);
      fbuf[4] <= tx_req.retries;
      fbuf[5] <= delivery_code(tx_req.delivery);
      fbuf[6] <= tx_req.route_discovered ? `DISC_ROUTE : `DISC_NONE;
      flen <= `TX_LEN;
    end else if (take_cmd) begin
      fbuf[0] <= `RSP_AT;
      fbuf[1] <= cmd_req.frame_id;
      fbuf[2] <= cmd_req.cmd_name[15:8];
      fbuf[3] <= cmd_req.cmd_name[7:0];
      fbuf[4] <= outcome_code(cmd_req.outcome);
      for (int i = 0; i < DATA_BYTES; i++) begin
        fbuf[5 + i] <= cmd_req.data[(`CMD_DATA_MAX - 1 - i) * 8 +: 8];
      end
      if (cmd_req.is_write) begin
        flen <= `CMD_FIXED_LEN;
      end else if (int'(cmd_req.data_len) > DATA_BYTES) begin
        flen <= 8'(5 + DATA_BYTES);
      end else begin
        flen <= `CMD_FIXED_LEN + 8'(cmd_req.data_len);
      end
    end
  end

  // ==========================================================================
  // Byte serialiser

  logic adv;
  assign adv = ce && (!out_valid || out_ready);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= S_IDLE;
      out_byte <= 8'h00;
      out_valid <= 1'b0;
      idx <= 8'h00;
      sum <= 8'h00;
    end else if (ce) begin
      if (idle) begin
        if (out_valid && out_ready) begin
          out_valid <= 1'b0;
        end
        if (go) begin
          state <= S_DELIM;
        end
      end else if (adv) begin
        unique case (state)
          S_DELIM: begin
            out_byte <= `FRAME_DELIM;
            out_valid <= 1'b1;
            state <= S_LEN_HI;
          end
          S_LEN_HI: begin
            out_byte <= `LEN_MSB;
            state <= S_LEN_LO;
          end
          S_LEN_LO: begin
            out_byte <= flen;
            idx <= 8'h00;
            sum <= 8'h00;
            state <= S_DATA;
          end
          S_DATA: begin
            out_byte <= fbuf[idx[$clog2(FLEN)-1:0]];
            sum <= sum + fbuf[idx[$clog2(FLEN)-1:0]];
            idx <= idx + 8'h01;
            if (idx == flen - 8'h01) begin
              state <= S_CSUM;
            end
          end
          S_CSUM: begin
            out_byte <= `CSUM_BASE - sum;
            state <= S_IDLE;
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy <= 1'b1;
    end else if (ce) begin
      busy <= !idle || go || pwr_pend;
    end
  end

  // ==========================================================================
  // Checks on the emitted stream and the frame data buffer

  logic [7:0] obs_pos;
  logic [7:0] obs_len;
  logic [7:0] obs_sum;
  logic [7:0] obs_type;
  logic obs_first;
  logic hs;
  assign hs = ce && out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      obs_pos <= 8'h00;
      obs_len <= 8'h00;
      obs_sum <= 8'h00;
      obs_type <= 8'h00;
      obs_first <= 1'b1;
    end else if (hs) begin
      if (obs_pos >= 8'h03 && obs_pos == obs_len + 8'h03) begin
        obs_pos <= 8'h00;
        obs_first <= 1'b0;
      end else begin
        obs_pos <= obs_pos + 8'h01;
      end
      if (obs_pos == 8'h02) begin
        obs_len <= out_byte;
        obs_sum <= 8'h00;
      end else begin
        obs_sum <= obs_sum + out_byte;
      end
      if (obs_pos == 8'h03) begin
        obs_type <= out_byte;
      end
    end
  end

  a_start_delim: assert property (@(posedge ref_clk) disable iff (rst)
    out_valid && obs_pos == 8'h00 |-> out_byte == 8'h7e)
    else $error("frame does not open with delimiter");

  a_checksum_byte: assert property (@(posedge ref_clk) disable iff (rst)
    out_valid && obs_pos >= 8'h03 && obs_pos == obs_len + 8'h03 |-> out_byte == 8'hff - obs_sum)
    else $error("checksum byte wrong");

  a_frame_type: assert property (@(posedge ref_clk) disable iff (rst)
    out_valid && obs_pos == 8'h03 |-> out_byte inside {8'h88, 8'h8a, 8'h8b})
    else $error("unexpected frame type");

  a_powerup_status: assert property (@(posedge ref_clk) disable iff (rst)
    out_valid && obs_first && obs_pos == 8'h04 |-> obs_type == 8'h8a && out_byte == 8'h00)
    else $error("first frame is not hardware reset status");

  a_tx_id_nonzero: assert property (@(posedge ref_clk) disable iff (rst)
    out_valid && obs_pos == 8'h04 && obs_type == 8'h8b |-> out_byte != 8'h00)
    else $error("result frame sent for zero identifier");

  a_fail_address: assert property (@(posedge ref_clk) disable iff (rst)
    take_tx && tx_req.delivery != api_response_pkg::DLV_OK
    |=> fbuf[2] == 8'hff && fbuf[3] == 8'hfd)
    else $error("failed delivery address not unknown");

  a_cmd_id_echo: assert property (@(posedge ref_clk) disable iff (rst)
    take_cmd |=> fbuf[1] == $past(cmd_req.frame_id) && fbuf[0] == 8'h88)
    else $error("command response identifier not echoed");

  a_write_no_data: assert property (@(posedge ref_clk) disable iff (rst)
    take_cmd && cmd_req.is_write |=> flen == 8'h05)
    else $error("write response carries data");

  a_wake_code: assert property (@(posedge ref_clk) disable iff (rst)
    take_stat && stat_event == api_response_pkg::EV_WAKE |=> fbuf[1] == 8'h0b)
    else $error("wake status code wrong");

  a_byte_hold: assert property (@(posedge ref_clk) disable iff (rst)
    out_valid && !out_ready |=> out_valid && $stable(out_byte))
    else $error("byte dropped under back-pressure");

endmodule

`default_nettype wire

/* logic/api_response_frame_builder_params.svh */
// Constants of the serial API response framer: frame codes, field codes, sizes.
// Assumes inclusion by bare name from the package and the framer module.
`ifndef API_RESPONSE_FRAME_BUILDER_PARAMS_SVH
`define API_RESPONSE_FRAME_BUILDER_PARAMS_SVH

// ==========================================================================
// Framing
`define FRAME_DELIM 8'h7e
`define CSUM_BASE 8'hff
`define LEN_MSB 8'h00

// ==========================================================================
// Frame type codes
`define REQ_AT_LOCAL 8'h08
`define REQ_AT_QUEUED 8'h09
`define REQ_TX_PLAIN 8'h10
`define REQ_TX_EXPLICIT 8'h11
`define RSP_AT 8'h88
`define RSP_MODEM 8'h8a
`define RSP_TX 8'h8b

// ==========================================================================
// Field codes
`define CMD_ST_OK 8'h00
`define CMD_ST_ERROR 8'h01
`define CMD_ST_BAD_CMD 8'h02
`define CMD_ST_BAD_PARAM 8'h03
`define MODEM_HW_RESET 8'h00
`define MODEM_WATCHDOG 8'h01
`define MODEM_WAKE 8'h0b
`define MODEM_SLEEP 8'h0c
`define DLV_CODE_OK 8'h00
`define DLV_CODE_MAC_ACK 8'h01
`define DLV_CODE_CCA 8'h02
`define DLV_CODE_NET_ACK 8'h21
`define DLV_CODE_NO_ROUTE 8'h25
`define DLV_CODE_RESOURCE 8'h31
`define DLV_CODE_INTERNAL 8'h32
`define DISC_NONE 8'h00
`define DISC_ROUTE 8'h02
`define ADDR_UNKNOWN 16'hfffd

// ==========================================================================
// Sizes (frame-data byte counts)
`define CMD_DATA_MAX 8
`define CMD_FIXED_LEN 8'h05
`define MODEM_LEN 8'h02
`define TX_LEN 8'h07

`endif

/* logic/api_response_pkg.sv */
// Types shared by the response framer and its users.
// Assumes the params header is on the include path.
`default_nettype none
`include "api_response_frame_builder_params.svh"

package api_response_pkg;

  typedef enum logic [1:0] {CMD_OK, CMD_ERROR, CMD_BAD_CMD, CMD_BAD_PARAM} cmd_outcome_t;
  typedef enum logic [1:0] {EV_HW_RESET, EV_WATCHDOG, EV_WAKE, EV_SLEEP} modem_event_t;
  typedef enum logic [2:0] {
    DLV_OK, DLV_MAC_ACK, DLV_CCA, DLV_NET_ACK, DLV_NO_ROUTE, DLV_RESOURCE, DLV_INTERNAL
  } delivery_t;

  typedef struct packed {
    logic [7:0] req_type;
    logic [7:0] frame_id;
    logic [15:0] cmd_name;
    cmd_outcome_t outcome;
    logic is_write;
    logic [3:0] data_len;
    logic [8*`CMD_DATA_MAX-1:0] data;
  } cmd_resp_t;

  typedef struct packed {
    logic [7:0] req_type;
    logic [7:0] frame_id;
    logic [15:0] net_addr;
    logic [7:0] retries;
    delivery_t delivery;
    logic route_discovered;
  } tx_result_t;

endpackage

`default_nettype wire

/* dv/host_frame_sink.sv */
// Host model: byte sink with optional stalls that parses API frames.
// Assumes ref_clk rising edge and synchronous active-high rst.
`default_nettype none

module host_frame_sink (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Byte stream
  input wire logic [7:0] out_byte,
  input wire logic out_valid,
  output logic out_ready,
  // Control and results
  input wire logic stall,
  output int frames,
  output int bad
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos;
  logic [7:0] len;
  logic [7:0] sum;

  // ==========================================================================
  // Acceptance
  // bytes accepted whenever not stalled
  assign out_ready = !stall;

  // ==========================================================================
  // Frame parse
  // delimiter length checksum
  always @(posedge ref_clk) begin
    if (rst) begin
      pos <= 0;
    end else if (out_valid && out_ready) begin
      pos <= pos + 1;
      case (pos)
        0: begin
          sum <= 8'h00;
          if (out_byte !== 8'h7e) bad <= bad + 1;
        end
        1: if (out_byte !== 8'h00) bad <= bad + 1;
        2: len <= out_byte;
        default: begin
          if (pos == int'(len) + 3) begin
            pos <= 0;
            frames <= frames + 1;
            if (out_byte !== 8'hff - sum) bad <= bad + 1;
          end else begin
            sum <= sum + out_byte;
          end
        end
      endcase
    end
  end
endmodule

`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench of the response framer with a stalling host sink.
// Assumes the logic/ package and framer compiled first.
`default_nettype none
`define CHECK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic cmd_valid = 1'b0;
  logic stat_valid = 1'b0;
  logic tx_valid = 1'b0;
  api_response_pkg::cmd_resp_t cmd_req = '0;
  api_response_pkg::modem_event_t stat_event = api_response_pkg::EV_HW_RESET;
  api_response_pkg::tx_result_t tx_req = '0;
  logic cmd_ready, stat_ready, tx_ready, out_valid, out_ready, busy;
  logic [7:0] out_byte;
  logic [7:0] exp_b;
  logic [31:0] rnd;
  logic [7:0] exp_q[$];
  int frames, bad, fail_count, n_tests, nframes;
  integer seed = 32'h8d96b0db;
  logic [7:0] pwr[6] = '{8'h7e, 8'h00, 8'h02, 8'h8a, 8'h00, 8'h75};
  logic [7:0] stat_code[4] = '{8'h00, 8'h01, 8'h0b, 8'h0c};
  logic [7:0] dlv_code[7] = '{8'h00, 8'h01, 8'h02, 8'h21, 8'h25, 8'h31, 8'h32};

  api_response_frame_builder i_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .cmd_valid(cmd_valid), .cmd_req(cmd_req), .cmd_ready(cmd_ready),
    .stat_valid(stat_valid), .stat_event(stat_event), .stat_ready(stat_ready),
    .tx_valid(tx_valid), .tx_req(tx_req), .tx_ready(tx_ready),
    .out_byte(out_byte), .out_valid(out_valid), .out_ready(out_ready), .busy(busy));
  host_frame_sink i_host (.ref_clk(ref_clk), .rst(rst), .out_byte(out_byte),
    .out_valid(out_valid), .out_ready(out_ready), .stall(stall), .frames(frames), .bad(bad));

  initial forever #5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) begin
    rnd = $random(seed);
    stall <= slow && rnd[0];
    // Enable drops only while the sink stalls, so no byte moves while frozen
    ce <= !(slow && rnd[0] && rnd[1]);
  end

  task final_report;
    $display("Counts: tests=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================================
  // Expected frames
  task note(input logic [7:0] d[$]);
    logic [7:0] sum;
    sum = 8'h00;
    nframes++;
    exp_q.push_back(8'h7e);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'(d.size()));
    foreach (d[i]) begin
      exp_q.push_back(d[i]);
      sum += d[i];
    end
    exp_q.push_back(8'hff - sum);
  endtask

  task note_take(input logic ts, input logic tt, input logic tc);
    logic [7:0] d[$];
    logic [15:0] a;
    if (ts) note('{8'h8a, stat_code[stat_event]});
    if (tt && tx_req.frame_id != 8'h00 &&
        (tx_req.req_type == 8'h10 || tx_req.req_type == 8'h11)) begin
      a = (tx_req.delivery == api_response_pkg::DLV_OK) ? tx_req.net_addr : 16'hfffd;
      note('{8'h8b, tx_req.frame_id, a[15:8], a[7:0], tx_req.retries,
        dlv_code[tx_req.delivery], tx_req.route_discovered ? 8'h02 : 8'h00});
    end
    if (tc && (cmd_req.req_type == 8'h08 || cmd_req.req_type == 8'h09)) begin
      d = '{8'h88, cmd_req.frame_id, cmd_req.cmd_name[15:8], cmd_req.cmd_name[7:0],
        8'(cmd_req.outcome)};
      for (int i = 0; i < 8 && i < cmd_req.data_len && !cmd_req.is_write; i++)
        d.push_back(cmd_req.data[63 - 8 * i -: 8]);
      note(d);
    end
  endtask

  // ==========================================================================
  // Request driver and waits
  task go(input logic s, input logic t, input logic c);
    logic ts, tt, tc;
    // A full low cycle between requests, never two writes in one step
    @(negedge ref_clk);
    stat_valid = s;
    tx_valid = t;
    cmd_valid = c;
    for (int n = 0; n < 300 && (stat_valid || tx_valid || cmd_valid); n++) begin
      @(posedge ref_clk);
      ts = ce && stat_valid && stat_ready === 1'b1;
      tt = ce && tx_valid && tx_ready === 1'b1;
      tc = ce && cmd_valid && cmd_ready === 1'b1;
      note_take(ts, tt, tc);
      @(negedge ref_clk);
      if (ts) stat_valid = 1'b0;
      if (tt) tx_valid = 1'b0;
      if (tc) cmd_valid = 1'b0;
    end
    if (stat_valid || tx_valid || cmd_valid) begin
      fail_count++;
      final_report;
    end
  endtask

  task drain;
    for (int n = 0; n < 600 && (exp_q.size() != 0 || busy !== 1'b0); n++)
      @(negedge ref_clk);
    if (exp_q.size() != 0 || busy !== 1'b0) begin
      fail_count++;
      final_report;
    end
  endtask

  task reset_check;
    foreach (pwr[i]) exp_q.push_back(pwr[i]);
    nframes++;
    repeat (10) @(negedge ref_clk);
    `CHECK(busy, 1'b1)
    `CHECK({out_valid, stat_ready, tx_ready, cmd_ready}, 4'h0)
    rst = 1'b0;
    drain;
  endtask

  // ==========================================================================
  // Output watcher
  always @(posedge ref_clk) begin
    if (!rst && ce && out_valid === 1'b1 && out_ready) begin
      exp_b = exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx;
      `CHECK(out_byte, exp_b)
    end
  end

  initial begin
    reset_check;
    for (int i = 0; i < 4; i++) begin
      stat_event = api_response_pkg::modem_event_t'(i);
      go(1'b1, 1'b0, 1'b0);
    end
    slow = 1'b1;
    for (int i = 0; i < 12; i++) begin
      cmd_req.req_type = (i == 10) ? 8'h42 : (i % 2 != 0) ? 8'h09 : 8'h08;
      cmd_req.frame_id = (i == 3) ? 8'h00 : (i == 5) ? cmd_req.frame_id : 8'($random(seed));
      cmd_req.cmd_name = 16'($random(seed));
      cmd_req.outcome = api_response_pkg::cmd_outcome_t'(i % 4);
      cmd_req.is_write = (i % 3 == 0);
      cmd_req.data_len = 4'($random(seed));
      cmd_req.data = {$random(seed), $random(seed)};
      go(1'b0, 1'b0, 1'b1);
    end
    for (int i = 0; i < 16; i++) begin
      tx_req.req_type = (i == 14) ? 8'h12 : (i % 2 != 0) ? 8'h11 : 8'h10;
      tx_req.frame_id = (i == 7) ? 8'h00 : 8'($random(seed)) | 8'h01;
      tx_req.net_addr = 16'($random(seed));
      tx_req.retries = 8'($random(seed));
      tx_req.delivery = api_response_pkg::delivery_t'(i % 7);
      tx_req.route_discovered = 1'($random(seed));
      go(1'b0, 1'b1, 1'b0);
    end
    go(1'b1, 1'b1, 1'b1);
    drain;
    rst = 1'b1;
    reset_check;
    `CHECK(bad, 0)
    `CHECK(frames, nframes)
    final_report;
  end
endmodule

`default_nettype wire
